// *** ima_pkg.sv ***
// package for the inbound message interrupt action block
// assumes one core clock; shared by the top and the per-source channel
// ============================================================
// constants and types
// ============================================================
package ima_pkg;

	// register bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register offsets (byte addresses)
	localparam logic [7:0] OFS_STATUS = 8'he8; // irq_status_reg
	localparam logic [7:0] OFS_CTRL = 8'hec; // inbound_irq_action_control
	localparam logic [7:0] OFS_MASK = 8'hf0; // interrupt mask
	localparam logic [7:0] OFS_GATE = 8'hf4; // msi enable / legacy disable

	// sources, pins and selector fields
	localparam int N_SRC = 4;
	localparam int N_PIN = 4;
	localparam int SEL_W = 3;
	localparam int SEL_LSB_BASE = 0;
	localparam int CTRL_USED = 12;

	// reset values
	localparam logic [11:0] CTRL_RST = 12'h000;
	localparam logic [3:0] STATUS_RST = 4'h0;
	localparam logic [3:0] MASK_RST = 4'h0;
	localparam logic [1:0] GATE_RST = 2'h0;

	// gate register bit positions
	localparam int GATE_MSI_EN_BIT = 0;
	localparam int GATE_INTX_DIS_BIT = 1;

	// selector encodings
	localparam logic [2:0] SEL_OFF = 3'h0;
	localparam logic [2:0] SEL_MSI = 3'h1;
	localparam logic [2:0] SEL_INTA = 3'h2;
	localparam logic [2:0] SEL_INTB = 3'h3;
	localparam logic [2:0] SEL_INTC = 3'h4;
	localparam logic [2:0] SEL_INTD = 3'h5;

	// kinds of upstream message
	typedef enum logic [1:0] {
		MK_MSI,
		MK_ASSERT,
		MK_DEASSERT
	} ima_kind_t;

	// one upstream message request
	typedef struct packed {
		ima_kind_t kind;
		logic [1:0] pin;
		logic [1:0] src;
	} ima_msg_t;

endpackage : ima_pkg

// *** ima_chan.sv ***
// one inbound message source: sticky status bit and pending msi request
// assumes synchronous inputs on the core clock; clear is a write-one pulse
`timescale 1ns/1ps
// ============================================================
// per-source channel
// ============================================================
module ima_chan (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// status events
	input wire logic i_set,
	input wire logic i_clr,
	// configuration
	input wire logic [2:0] i_sel,
	input wire logic i_msi_en,
	// msi grant from the arbiter
	input wire logic i_msi_take,
	// state
	output logic o_status,
	output logic o_msi_pend
);

	logic next_status;
	logic next_msi_pend;
	logic rise;
	logic fire_msi;

	// status set by far-side write, cleared by write one; set wins
	assign next_status = i_set | (o_status & ~i_clr); // RULE14
	assign rise = i_set & ~o_status;

	// msi only on a rising status, selector msi, msi enabled
	assign fire_msi = rise & (i_sel == ima_pkg::SEL_MSI) & i_msi_en; // RULE10 RULE6 RULE5
	// pending drops when taken or when msi gets disabled; new fire wins
	assign next_msi_pend = fire_msi | (o_msi_pend & ~i_msi_take & i_msi_en); // RULE6

	// state flops
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_status <= 1'b0;
			o_msi_pend <= 1'b0;
		end else begin
			o_status <= next_status;
			o_msi_pend <= next_msi_pend;
		end
	end

endmodule // ima_chan

// *** ima_top.sv ***
// inbound message interrupt action selector with register port
// assumes synchronous inputs, one core clock, an upstream requester with ready
// How it works
// [RULE1] bits 2:0 choose the action for inbound message source 0
// [RULE2] bits 5:3 choose the action for inbound message source 1
// [RULE3] bits 8:6 choose the action for inbound message source 2
// [RULE4] bits 11:9 choose the action for inbound message source 3
// [RULE5] act when status sets; for legacy pins also act when it clears
// [RULE6] an msi goes out only while the msi enable bit is set; an msi loaded before it clears still goes out
// [RULE7] legacy pin asserts are suppressed while the legacy disable bit is set; a pin already asserted still gets its deassert; a loaded assert still goes out
// [RULE8] software keeps a selector unchanged while its status bit is set
// [RULE9] selector zero masks the source: no message at all
// [RULE10] selector one sends an msi for the source
// [RULE11] selector two drives pin A assert and deassert messages
// [RULE12] selectors three to five drive pins B, C and D
// [RULE13] selectors six and seven are reserved; software never writes them
// [RULE14] far-side write sets the status bit; writing one clears it
// [RULE15] assert on rise, deassert on clear, one outstanding assert per pin
`timescale 1ns/1ps
// ============================================================
// top
// ============================================================
module ima_top (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rd_data,
	// far-side outbound message writes, one pulse per source
	input wire logic [3:0] i_far_msg_wr,
	// upstream message request
	output logic o_msg_valid,
	output ima_pkg::ima_msg_t o_msg,
	input wire logic i_msg_ready,
	// interrupt to local software
	output logic o_irq
);

	// ============================================================
	// declarations
	// ============================================================
	logic [11:0] ctrl;
	logic [3:0] mask;
	logic [1:0] gate;
	logic [3:0] status;
	logic [3:0] msi_pend;
	logic [3:0] pin_sent;
	logic [3:0] pin_want;
	logic [2:0] sel [4];
	logic [3:0] pin_hit [4];
	logic [3:0] status_clr;
	logic [3:0] msi_take;
	logic [3:0] pin_take;
	logic [3:0] next_pin_sent;
	logic [31:0] rd_word;
	logic [31:0] next_rd_data;
	logic hit_status;
	logic hit_ctrl;
	logic hit_mask;
	logic hit_gate;
	logic wr_status;
	logic wr_ctrl;
	logic wr_mask;
	logic wr_gate;
	logic msi_en;
	logic intx_dis;
	logic load;
	logic cand_valid;
	ima_pkg::ima_msg_t cand;
	logic [3:0] pin_pick;
	logic [3:0] msi_pick;

	// ============================================================
	// register decode
	// ============================================================
	// address match per register
	assign hit_status = (i_addr == ima_pkg::OFS_STATUS);
	assign hit_ctrl = (i_addr == ima_pkg::OFS_CTRL);
	assign hit_mask = (i_addr == ima_pkg::OFS_MASK);
	assign hit_gate = (i_addr == ima_pkg::OFS_GATE);

	// write strobes per register
	assign wr_status = i_wr & hit_status;
	assign wr_ctrl = i_wr & hit_ctrl;
	assign wr_mask = i_wr & hit_mask;
	assign wr_gate = i_wr & hit_gate;

	// gate bits
	assign msi_en = gate[ima_pkg::GATE_MSI_EN_BIT];
	assign intx_dis = gate[ima_pkg::GATE_INTX_DIS_BIT];

	// read mux, unmapped reads as zero
	assign rd_word = hit_status ? {28'h0000000, status} :
		hit_ctrl ? {20'h00000, ctrl} :
		hit_mask ? {28'h0000000, mask} :
		hit_gate ? {30'h00000000, gate} : 32'h00000000;
	// read data only in the cycle after the strobe
	assign next_rd_data = i_rd ? rd_word : 32'h00000000;

	// write-one-to-clear of status
	assign status_clr = wr_status ? i_wr_data[3:0] : 4'h0;

	// ============================================================
	// registers
	// ============================================================
	// control, mask, gate and read data
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			ctrl <= ima_pkg::CTRL_RST;
			mask <= ima_pkg::MASK_RST;
			gate <= ima_pkg::GATE_RST;
			o_rd_data <= 32'h00000000;
		end else begin
			if (wr_ctrl) begin
				ctrl <= i_wr_data[ima_pkg::CTRL_USED-1:0];
			end
			if (wr_mask) begin
				mask <= i_wr_data[3:0];
			end
			if (wr_gate) begin
				gate <= i_wr_data[1:0];
			end
			o_rd_data <= next_rd_data;
		end
	end

	// local interrupt: any sticky status bit whose mask bit is set
	assign o_irq = |(status & mask);

	// ============================================================
	// selector fields and channels
	// ============================================================
	// field i sits at lsb base + 3*i: 2:0, 5:3, 8:6, 11:9
	assign sel[0] = ctrl[ima_pkg::SEL_LSB_BASE +: ima_pkg::SEL_W]; // RULE1
	assign sel[1] = ctrl[ima_pkg::SEL_LSB_BASE + ima_pkg::SEL_W +: ima_pkg::SEL_W]; // RULE2
	assign sel[2] = ctrl[ima_pkg::SEL_LSB_BASE + 2*ima_pkg::SEL_W +: ima_pkg::SEL_W]; // RULE3
	assign sel[3] = ctrl[ima_pkg::SEL_LSB_BASE + 3*ima_pkg::SEL_W +: ima_pkg::SEL_W]; // RULE4

	// one channel per source, plus its pin decode
	for (genvar i = 0; i < ima_pkg::N_SRC; i++) begin : g_src
		ima_chan u_chan (
			.i_clk(i_clk),
			.i_rstn(i_rstn),
			.i_set(i_far_msg_wr[i]),
			.i_clr(status_clr[i]),
			.i_sel(sel[i]),
			.i_msi_en(msi_en),
			.i_msi_take(msi_take[i]),
			.o_status(status[i]),
			.o_msi_pend(msi_pend[i])
		);
		// pin p selected by code INTA+p; zero, msi and reserved hit nothing
		for (genvar p = 0; p < ima_pkg::N_PIN; p++) begin : g_pin
			assign pin_hit[p][i] = (sel[i] == 3'(ima_pkg::SEL_INTA + p)); // RULE11 RULE12 RULE9
		end
	end

	// pin wanted while any source on it holds status; off when disabled
	for (genvar p = 0; p < ima_pkg::N_PIN; p++) begin : g_want
		assign pin_want[p] = (|(status & pin_hit[p])) & ~intx_dis; // RULE5 RULE7
	end

	// ============================================================
	// arbiter: pin changes first, then msi, lowest index first
	// ============================================================
	always_comb begin
		cand_valid = 1'b0;
		cand = '0;
		pin_pick = 4'h0;
		msi_pick = 4'h0;
		// msi requests, scanned downward so index 0 wins; none while msi is disabled
		for (int i = ima_pkg::N_SRC - 1; i >= 0; i--) begin
			if (msi_pend[i] && msi_en) begin // RULE6
				cand_valid = 1'b1;
				msi_pick = 4'h1 << i;
				cand.kind = ima_pkg::MK_MSI; // RULE10
				cand.pin = 2'h0;
				cand.src = 2'(i);
			end
		end
		// pin level changes override msi
		for (int p = ima_pkg::N_PIN - 1; p >= 0; p--) begin
			if (pin_want[p] != pin_sent[p]) begin
				cand_valid = 1'b1;
				msi_pick = 4'h0;
				pin_pick = 4'h1 << p;
				cand.kind = pin_want[p] ? ima_pkg::MK_ASSERT : ima_pkg::MK_DEASSERT; // RULE15
				cand.pin = 2'(p);
				cand.src = 2'h0;
			end
		end
	end

	// output slot free when empty or being accepted
	assign load = ~o_msg_valid | i_msg_ready;
	assign msi_take = load ? msi_pick : 4'h0;
	assign pin_take = load ? pin_pick : 4'h0;
	// a granted pin message flips the outstanding state of that pin
	assign next_pin_sent = pin_sent ^ pin_take; // RULE15

	// ============================================================
	// message output stage
	// ============================================================
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_msg_valid <= 1'b0;
			o_msg <= '0;
			pin_sent <= 4'h0;
		end else begin
			pin_sent <= next_pin_sent;
			if (load) begin
				o_msg_valid <= cand_valid;
				o_msg <= cand;
			end
		end
	end

	// ============================================================
	// assertions
	// ============================================================
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	// source 0 with msi selector and msi enabled raises a pending msi
	property p_src0_msi;
		i_far_msg_wr[0] && !status[0] && ctrl[2:0] == 3'h1 && msi_en |=> msi_pend[0];
	endproperty
	a_src0_msi: assert property (p_src0_msi) else $error("source 0 msi not raised"); // RULE1

	// source 1 on pin A wants that pin while status stands
	property p_src1_inta;
		status[1] && ctrl[5:3] == 3'h2 && !intx_dis |-> pin_want[0];
	endproperty
	a_src1_inta: assert property (p_src1_inta) else $error("source 1 did not want pin A"); // RULE2

	// source 2 on pin C wants pin C
	property p_src2_intc;
		status[2] && ctrl[8:6] == 3'h4 && !intx_dis |-> pin_want[2];
	endproperty
	a_src2_intc: assert property (p_src2_intc) else $error("source 2 did not want pin C"); // RULE3

	// source 3 on pin D wants pin D
	property p_src3_intd;
		status[3] && ctrl[11:9] == 3'h5 && !intx_dis |-> pin_want[3];
	endproperty
	a_src3_intd: assert property (p_src3_intd) else $error("source 3 did not want pin D"); // RULE4

	// a clear of a wanted pin leads to a deassert within a few cycles
	property p_pin_clear;
		pin_sent[1] && !pin_want[1] && i_msg_ready ##1 (i_msg_ready && !pin_want[1]) [*3] |=> !pin_sent[1];
	endproperty
	a_pin_clear: assert property (p_pin_clear) else $error("pin B deassert late"); // RULE5

	// with msi disabled no msi stays pending
	property p_msi_gate;
		!msi_en |=> msi_pend == 4'h0;
	endproperty
	a_msi_gate: assert property (p_msi_gate) else $error("msi pending while disabled"); // RULE6

	// with legacy disabled no pin is wanted
	property p_intx_gate;
		intx_dis |-> pin_want == 4'h0;
	endproperty
	a_intx_gate: assert property (p_intx_gate) else $error("pin wanted while disabled"); // RULE7

	// a masked source never raises a message
	property p_masked;
		ctrl[2:0] == 3'h0 && !msi_pend[0] |-> !pin_hit[0][0] && !pin_hit[1][0] && !pin_hit[2][0] && !pin_hit[3][0]
			##1 !msi_pend[0];
	endproperty
	a_masked: assert property (p_masked) else $error("masked source produced a request"); // RULE9

	// far-side write sets status; write one alone clears it
	property p_status_set;
		i_far_msg_wr[0] |=> status[0] ##1 (status[0] || $past(status_clr[0]));
	endproperty
	a_status_set: assert property (p_status_set) else $error("status not set by far write"); // RULE14

	property p_status_clr;
		wr_status && i_wr_data[0] && !i_far_msg_wr[0] |=> !status[0];
	endproperty
	a_status_clr: assert property (p_status_clr) else $error("status not cleared by write one"); // RULE14

	// an assert on the wire means the pin is outstanding; with the output empty a mismatch is served next cycle
	property p_assert_outstanding;
		o_msg_valid && o_msg.kind == ima_pkg::MK_ASSERT |-> pin_sent[o_msg.pin];
	endproperty
	a_assert_outstanding: assert property (p_assert_outstanding) else $error("assert without outstanding pin"); // RULE15

	property p_pin_served;
		!o_msg_valid && pin_want != pin_sent |=> o_msg_valid && o_msg.kind != ima_pkg::MK_MSI;
	endproperty
	a_pin_served: assert property (p_pin_served) else $error("pin change not sent"); // RULE11

	// control writes land in the four selector fields
	property p_sel_fields;
		wr_ctrl |=> sel[0] == $past(i_wr_data[2:0]) && sel[1] == $past(i_wr_data[5:3])
			&& sel[2] == $past(i_wr_data[8:6]) && sel[3] == $past(i_wr_data[11:9]);
	endproperty
	a_sel_fields: assert property (p_sel_fields) else $error("selector field not written"); // RULE1 RULE2 RULE3 RULE4

	// a pending msi only comes from a rising status under msi selector and enable
	property p_msi_source;
		msi_pend[1] && !$past(msi_pend[1]) |-> $past(sel[1]) == ima_pkg::SEL_MSI && $past(msi_en);
	endproperty
	a_msi_source: assert property (p_msi_source) else $error("msi pending without msi selector"); // RULE10

	// no msi is loaded while msi is disabled
	property p_msi_off_quiet;
		!msi_en && load |=> !(o_msg_valid && o_msg.kind == ima_pkg::MK_MSI);
	endproperty
	a_msi_off_quiet: assert property (p_msi_off_quiet) else $error("msi loaded while disabled"); // RULE6

	// no assert is loaded while legacy pins are disabled
	property p_intx_no_assert;
		intx_dis && load |=> !(o_msg_valid && o_msg.kind == ima_pkg::MK_ASSERT);
	endproperty
	a_intx_no_assert: assert property (p_intx_no_assert) else $error("assert loaded while disabled"); // RULE7

	// a deassert on the wire means the pin is no longer outstanding
	property p_deassert_released;
		o_msg_valid && o_msg.kind == ima_pkg::MK_DEASSERT |-> !pin_sent[o_msg.pin];
	endproperty
	a_deassert_released: assert property (p_deassert_released) else $error("deassert with pin outstanding"); // RULE15

	// pin A is wanted only while some source selects it and holds status
	property p_pin_a_cause;
		pin_want[0] |-> (status[0] && sel[0] == ima_pkg::SEL_INTA) || (status[1] && sel[1] == ima_pkg::SEL_INTA)
			|| (status[2] && sel[2] == ima_pkg::SEL_INTA) || (status[3] && sel[3] == ima_pkg::SEL_INTA);
	endproperty
	a_pin_a_cause: assert property (p_pin_a_cause) else $error("pin A wanted without a source"); // RULE11

	// pin D is wanted only while some source selects it and holds status
	property p_pin_d_cause;
		pin_want[3] |-> (status[0] && sel[0] == ima_pkg::SEL_INTD) || (status[1] && sel[1] == ima_pkg::SEL_INTD)
			|| (status[2] && sel[2] == ima_pkg::SEL_INTD) || (status[3] && sel[3] == ima_pkg::SEL_INTD);
	endproperty
	a_pin_d_cause: assert property (p_pin_d_cause) else $error("pin D wanted without a source"); // RULE12

	// scenarios of interest
	c_msi_sent: cover property (o_msg_valid && i_msg_ready && o_msg.kind == ima_pkg::MK_MSI);
	c_assert_sent: cover property (o_msg_valid && i_msg_ready && o_msg.kind == ima_pkg::MK_ASSERT);
	c_deassert_sent: cover property (o_msg_valid && i_msg_ready && o_msg.kind == ima_pkg::MK_DEASSERT);
	c_irq_raised: cover property (!o_irq ##1 o_irq);
	c_msi_discard: cover property (!msi_en && msi_pend != 4'h0);

endmodule // ima_top

// *** ima_host_model.sv ***
// upstream requester model: accepts message requests, stalls on command
// assumes the bench drives i_stall; accepted messages gather in got_q
`timescale 1ns/1ps
// ============================================================
// host model
// ============================================================
module ima_host_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// stall control from the bench
	input wire logic i_stall,
	// message link
	input wire logic i_valid,
	input wire ima_pkg::ima_msg_t i_msg,
	output logic o_ready
);
	ima_pkg::ima_msg_t got_q[$];
	ima_pkg::ima_msg_t last_msg;
	logic last_wait = 1'b0;
	int hold_err = 0;

	// ready drops while stalled, slow answers come from the bench
	assign o_ready = i_rstn & ~i_stall;

	// record accepted messages; a refused request must stand unchanged
	always @(posedge i_clk) begin
		if (last_wait && (!i_valid || i_msg !== last_msg))
			hold_err++;
		last_wait <= i_valid && !o_ready && i_rstn;
		last_msg <= i_msg;
		if (i_valid && o_ready)
			got_q.push_back(i_msg);
	end
endmodule // ima_host_model

// *** ima_tb_top.sv ***
// self-checking bench for the inbound message interrupt action block
// assumes ima_top and the host model; software side driven by tasks here
`timescale 1ns/1ps
// ============================================================
// bench top
// ============================================================
module ima_tb_top;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wr_data = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [3:0] i_far_msg_wr = 4'h0;
	logic stall = 1'b0;
	logic ready;
	logic o_msg_valid;
	logic o_irq;
	logic m;
	logic [31:0] o_rd_data;
	logic [31:0] rd;
	logic [31:0] v;
	logic [31:0] lfsr = 32'h0fce9762;
	logic [7:0] ofs[5] = '{ima_pkg::OFS_STATUS, ima_pkg::OFS_CTRL, ima_pkg::OFS_MASK, ima_pkg::OFS_GATE, 8'hfc};
	ima_pkg::ima_msg_t o_msg;
	ima_pkg::ima_msg_t exp_q[$];
	int bad_count = 0;
	int check_count = 0;

	always #25 i_clk = ~i_clk;

	ima_top u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr),
		.i_rd(i_rd), .o_rd_data(o_rd_data), .i_far_msg_wr(i_far_msg_wr), .o_msg_valid(o_msg_valid),
		.o_msg(o_msg), .i_msg_ready(ready), .o_irq(o_irq));
	ima_host_model u_host (.i_clk(i_clk), .i_rstn(i_rstn), .i_stall(stall), .i_valid(o_msg_valid),
		.i_msg(o_msg), .o_ready(ready));

	// one step of the pseudo-random shift register
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// pseudo-random stream; a quarter of cycles stall the host
	always @(posedge i_clk) begin
		lfsr <= lfsr_next(lfsr);
		stall <= lfsr[0] & lfsr[1];
	end

	function automatic ima_pkg::ima_msg_t mk(input ima_pkg::ima_kind_t k, input int p, input int s);
		return '{kind: k, pin: p[1:0], src: s[1:0]};
	endfunction

	task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, exp, got);
		end
	endtask

	task wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wr_data <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rd_data;
	endtask

	task far(input logic [3:0] b);
		@(posedge i_clk);
		i_far_msg_wr <= b;
		@(posedge i_clk);
		i_far_msg_wr <= 4'h0;
	endtask

	// wait for the expected messages, then compare in order
	task drain(input string n);
		int k;
		k = 0;
		while (u_host.got_q.size() < exp_q.size() && k < 40) begin
			@(posedge i_clk);
			k++;
		end
		repeat (4) @(posedge i_clk);
		chk({n, "_count"}, u_host.got_q.size(), exp_q.size());
		while (exp_q.size() > 0 && u_host.got_q.size() > 0)
			chk(n, u_host.got_q.pop_front(), exp_q.pop_front());
		exp_q.delete();
		u_host.got_q.delete();
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge i_clk);
		bad_count++;
		test_done();
	end

	// main sequence
	initial begin
		repeat (6) @(posedge i_clk);
		i_rstn <= 1'b1;
		foreach (ofs[j]) begin
			rreg(ofs[j], rd);
			chk("reset_val", rd, 32'h0);
		end
		@(posedge i_clk);
		#1 chk("rd_idle", o_rd_data, 32'h0);
		$display("test reset done");
		// random legal selectors read back; upper bits read zero
		for (int t = 0; t < 4; t++) begin
			v = 32'h0;
			for (int f = 0; f < 4; f++)
				v[3*f+:3] = 3'(lfsr[4*f+:4] % 6);
			wreg(ima_pkg::OFS_CTRL, v | 32'hfffff000);
			rreg(ima_pkg::OFS_CTRL, rd);
			chk("ctrl_rb", rd, v);
		end
		$display("test control readback done");
		// selectors zero to five on every field under every gate setting
		for (int g = 0; g < 4; g++)
			for (int s = 0; s < 4; s++)
				for (int sel = 0; sel < 6; sel++) begin
					m = lfsr[5];
					wreg(ima_pkg::OFS_GATE, g);
					wreg(ima_pkg::OFS_CTRL, sel << (3 * s));
					wreg(ima_pkg::OFS_MASK, {31'h0, m} << s);
					far(4'h1 << s);
					if (sel == 1 && g[0])
						exp_q.push_back(mk(ima_pkg::MK_MSI, 0, s));
					if (sel > 1 && !g[1])
						exp_q.push_back(mk(ima_pkg::MK_ASSERT, sel - 2, 0));
					drain("set");
					rreg(ima_pkg::OFS_STATUS, rd);
					chk("status_set", rd, 32'h1 << s);
					chk("irq_set", o_irq, m);
					wreg(ima_pkg::OFS_STATUS, 32'h1 << s);
					if (sel > 1 && !g[1])
						exp_q.push_back(mk(ima_pkg::MK_DEASSERT, sel - 2, 0));
					drain("clr");
					rreg(ima_pkg::OFS_STATUS, rd);
					chk("status_clr", rd, 32'h0);
					chk("irq_clr", o_irq, 1'b0);
				end
		$display("test selector sweep done");
		// two msi sources and a shared pin, all set at once
		wreg(ima_pkg::OFS_GATE, 32'h1);
		wreg(ima_pkg::OFS_MASK, 32'hf);
		wreg(ima_pkg::OFS_CTRL, 32'h489);
		far(4'hf);
		exp_q.push_back(mk(ima_pkg::MK_ASSERT, 0, 0));
		exp_q.push_back(mk(ima_pkg::MK_MSI, 0, 0));
		exp_q.push_back(mk(ima_pkg::MK_MSI, 0, 1));
		drain("prio");
		chk("irq_all", o_irq, 1'b1);
		wreg(ima_pkg::OFS_STATUS, 32'h4);
		drain("shared");
		wreg(ima_pkg::OFS_STATUS, 32'h8);
		exp_q.push_back(mk(ima_pkg::MK_DEASSERT, 0, 0));
		drain("last");
		wreg(ima_pkg::OFS_STATUS, 32'h3);
		drain("msi_clr");
		// msi disabled in the very cycle the status sets: the pending msi is dropped
		wreg(ima_pkg::OFS_CTRL, 32'h1);
		@(posedge i_clk);
		i_addr <= ima_pkg::OFS_GATE;
		i_wr_data <= 32'h0;
		i_wr <= 1'b1;
		i_far_msg_wr <= 4'h1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		i_far_msg_wr <= 4'h0;
		drain("msi_off");
		wreg(ima_pkg::OFS_STATUS, 32'h1);
		drain("msi_off_clr");
		chk("msg_hold", u_host.hold_err, 32'h0);
		$display("test shared pin done");
		test_done();
	end
endmodule // ima_tb_top
